// ==== shared/tsr_pkg.sv ====
// Constants, states and helpers for the tape sense status reporter.
// Assumes one 50 MHz core clock; all timing counts derive from it.
package tsr_pkg;

    localparam int CLK_PERIOD_NS = 20;

    // Read bus timing around each sense byte strobe
    localparam int SETUP_NS = 100;
    localparam int STROBE_NS = 200;
    localparam int GAP_NS = 100;
    localparam logic [3:0] SETUP_CYC = 4'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] GAP_CYC = 4'((GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    localparam logic [2:0] LAST_BYTE_IDX = 3'h7;
    localparam logic [3:0] SENSE_BYTE_COUNT = 4'h8;

    // Opcode that starts the eight-byte sense transfer
    localparam logic [7:0] SENSE_OPCODE = 8'h04;

    localparam logic [5:0] REJ_NONE = 6'h00;
    localparam logic [5:0] REJ_NOT_READY = 6'h01;
    localparam logic [5:0] REJ_FILE_PROTECT = 6'h05;
    localparam logic [5:0] REJ_BAD_SEQUENCE = 6'h07;
    localparam logic [5:0] REJ_CACHE_EMPTY = 6'h10;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_SYNC = 3'h0;

    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_GAP} tsr_state_t;

    // Reject codes that also flag the operation as incomplete
    function automatic logic tsr_incomplete(input logic [5:0] code);
        logic hit;
        hit = 1'b0;
        case (code)
            6'h02, 6'h03, 6'h06, 6'h08, 6'h09, 6'h0c, 6'h0f, 6'h10, 6'h11:
                hit = 1'b1;
            default:
                hit = 1'b0;
        endcase
        return hit;
    endfunction

endpackage

// ==== src/tsr_sense.sv ====
// Sense status reporter: builds eight sense bytes and strobes them out
// on the read bus. Status inputs come from logic on core_clk; the command
// strobe and opcode come from interface pins and are synchronised here.
//
// Function
// RL1: After a Sense command, send exactly eight status bytes on the read bus.
// RL2: Place each byte on the bus first, then pulse the strobe high and low.
// RL3: The host accepts strobe pulses wider than the normal data pulse.
// RL4: Status bit 0 is the MSB and goes on the lowest-numbered bus line.
// RL5: Each byte carries an odd parity bit on the parity line.
// RL6: Unused status bits are driven as zero.
// RL7: Byte 0 bits 0-2: illegal command, not ready, streaming drive type.
// RL8: Byte 0 bit 3 set while a fault code shows on the panel.
// RL9: Byte 0 bit 4 set for any byte 3 error or byte 4 bits 0-2.
// RL10: A command during transfer-active sets overrun and illegal command.
// RL11: Byte 0 bit 6 is the OR of bits 0, 1, 3, 4 and 5.
// RL12: Byte 0 bit 7 set when byte 6 bits 0-2 show a corrected error.
// RL13: Byte 1 holds the last command bit-reversed.
// RL14: Byte 2 carries the eight tape status flags in order.
// RL15: Hard error line high whenever any byte 3 or 4 error is set.
// RL16: Byte 3 carries the eight read/write hard error flags; the code drives bit 4 as zero.
// RL17: Byte 4 carries BOT, PE write, reject, parity, incomplete, overrun.
// RL18: Byte 5: diagnostic mode, unused bit, six-bit reject code MSB first.
// RL19: Reject codes 01, 05, 07, 10 follow their conditions.
// RL20: Asterisked reject codes also set operation incomplete.
// RL21: Byte 6 carries corrected errors, gap selection and dead track P.
// RL22: Byte 7 flags dead data tracks 0 to 7.
// RL23: Transfer-active drops only after all status bytes are sent.
// RL24: Parity covers all eight data bits so nine bits hold odd ones.
`timescale 1ns/1ps
module tsr_sense (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic cmd_go_pin,
    input wire logic [7:0] cmd_code_pin,
    input wire logic illegal_cmd_evt,
    input wire logic not_ready,
    input wire logic streaming_drive,
    input wire logic fault_code_shown,
    input wire logic [0:7] tape_status,
    input wire logic [0:7] rw_errors,
    input wire logic bot_before_backward,
    input wire logic pe_write_track_err,
    input wire logic bus_parity_err,
    input wire logic op_incomplete_in,
    input wire logic overrun_err,
    input wire logic write_type_cmd,
    input wire logic bad_sequence,
    input wire logic cache_read_empty,
    input wire logic [5:0] reject_code_ext,
    input wire logic diag_mode,
    input wire logic [0:2] corrected_err,
    input wire logic [0:2] gap_select,
    input wire logic dead_track_p,
    input wire logic [0:7] dead_tracks,
    output logic read_bus_msb_line,
    output logic [1:7] read_bus_rest_lines,
    output logic read_bus_parity_line,
    output logic read_byte_strobe,
    output logic transfer_active,
    output logic hard_error_line
);

    typedef struct packed {
        tsr_pkg::tsr_state_t st;
        logic [3:0] cnt;
        logic [2:0] idx;
        logic [0:7][0:7] snap;
        logic [0:7] bus;
        logic par;
        logic strobe;
        logic active;
        logic hard;
        logic illegal;
        logic overrun;
        logic [7:0] last_cmd;
        logic [2:0] go_sync;
        logic go_lvl;
        logic [7:0] op_s1;
        logic [7:0] op_s2;
        logic [7:0] op_s3;
    } tsr_regs_t;

    tsr_regs_t q;
    tsr_regs_t d;

    logic go_rise;
    logic ovr_evt;
    logic [5:0] rej;
    logic [0:7] b0;
    logic [0:7] b1;
    logic [0:7] b2;
    logic [0:7] b3;
    logic [0:7] b4;
    logic [0:7] b5;
    logic [0:7] b6;
    logic [0:7] b7;
    logic data_chk;
    logic any_hard;
    logic snap_take;

    // Go is a pin: filtered level moves only when stages 2 and 3 agree
    assign go_rise = (q.go_sync[1] == q.go_sync[2]) && q.go_sync[2] && !q.go_lvl;
    assign ovr_evt = go_rise && q.active; // RL10

    always_comb
    begin
        // Fixed priority among the reject causes
        if (not_ready)
            rej = tsr_pkg::REJ_NOT_READY; // RL19
        else if (write_type_cmd && tape_status[3])
            rej = tsr_pkg::REJ_FILE_PROTECT; // RL19
        else if (bad_sequence)
            rej = tsr_pkg::REJ_BAD_SEQUENCE; // RL19
        else if (cache_read_empty)
            rej = tsr_pkg::REJ_CACHE_EMPTY; // RL19
        else
            rej = reject_code_ext;
    end

    // Bytes use status numbering: index 0 is the MSB
    assign b1 = q.last_cmd; // RL13
    assign b2 = tape_status; // RL14
    assign b3 = {rw_errors[0:3], 1'b0, rw_errors[5:7]}; // RL16 RL6
    assign b4 = {bot_before_backward, 1'b0, pe_write_track_err, 1'b0, // RL17 RL6
                 rej != tsr_pkg::REJ_NONE, bus_parity_err,
                 op_incomplete_in | tsr_pkg::tsr_incomplete(rej), overrun_err}; // RL20
    assign b5 = {diag_mode, 1'b0, rej}; // RL18 RL6
    assign b6 = {corrected_err, gap_select, 1'b0, dead_track_p}; // RL21 RL6
    assign b7 = dead_tracks; // RL22
    assign data_chk = (|b3) | (|b4[0:2]); // RL9
    assign any_hard = (|b3) | (|b4); // RL15

    always_comb
    begin
        b0[0] = q.illegal; // RL7
        b0[1] = not_ready; // RL7
        b0[2] = streaming_drive; // RL7
        b0[3] = fault_code_shown; // RL8
        b0[4] = data_chk; // RL9
        b0[5] = q.overrun; // RL10
        b0[6] = b0[0] | b0[1] | b0[3] | b0[4] | b0[5]; // RL11
        b0[7] = |corrected_err; // RL12
    end

    // Sticky flags clear as a sense takes its snapshot, so an overrun raised
    // during one transfer is still reported by the next one
    assign snap_take = go_rise && !q.active && (q.op_s3 == tsr_pkg::SENSE_OPCODE);

    always_comb
    begin
        d = q;
        d.go_sync = {q.go_sync[1:0], cmd_go_pin};
        d.op_s1 = cmd_code_pin;
        d.op_s2 = q.op_s1;
        d.op_s3 = q.op_s2;
        if (q.go_sync[1] == q.go_sync[2])
            d.go_lvl = q.go_sync[2];
        d.hard = any_hard; // RL15
        // Sticky flags: a new event wins over the snapshot clear
        d.illegal = illegal_cmd_evt | ovr_evt | (q.illegal & ~snap_take); // RL10
        d.overrun = ovr_evt | (q.overrun & ~snap_take); // RL10
        if (go_rise && !q.active && q.op_s3 != tsr_pkg::SENSE_OPCODE)
            d.last_cmd = q.op_s3; // RL13
        unique case (q.st)
            tsr_pkg::ST_IDLE:
            begin
                if (go_rise && !q.active && q.op_s3 == tsr_pkg::SENSE_OPCODE)
                begin
                    // Snapshot keeps the bytes coherent across the transfer
                    d.snap = {b0, b1, b2, b3, b4, b5, b6, b7};
                    d.active = 1'b1;
                    d.idx = 3'h0;
                    d.bus = b0; // RL2
                    d.par = ~^b0; // RL5 RL24
                    d.cnt = tsr_pkg::SETUP_CYC - 4'h1;
                    d.st = tsr_pkg::ST_SETUP;
                end
            end
            tsr_pkg::ST_SETUP:
            begin
                d.cnt = q.cnt - 4'h1;
                if (q.cnt == 4'h0)
                begin
                    d.strobe = 1'b1; // RL2
                    d.cnt = tsr_pkg::STROBE_CYC - 4'h1;
                    d.st = tsr_pkg::ST_STROBE;
                end
            end
            tsr_pkg::ST_STROBE:
            begin
                d.cnt = q.cnt - 4'h1;
                if (q.cnt == 4'h0)
                begin
                    d.strobe = 1'b0; // RL2
                    d.cnt = tsr_pkg::GAP_CYC - 4'h1;
                    d.st = tsr_pkg::ST_GAP;
                end
            end
            tsr_pkg::ST_GAP:
            begin
                d.cnt = q.cnt - 4'h1;
                if (q.cnt == 4'h0)
                begin
                    if (q.idx == tsr_pkg::LAST_BYTE_IDX)
                    begin
                        d.active = 1'b0; // RL23
                        d.bus = tsr_pkg::RST_BYTE;
                        d.par = 1'b0;
                        d.st = tsr_pkg::ST_IDLE;
                    end
                    else
                    begin
                        d.idx = q.idx + 3'h1; // RL1
                        d.bus = q.snap[q.idx + 3'h1]; // RL2
                        d.par = ~^q.snap[q.idx + 3'h1]; // RL5 RL24
                        d.cnt = tsr_pkg::SETUP_CYC - 4'h1;
                        d.st = tsr_pkg::ST_SETUP;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            q <= '0;
        else
            q <= d;
    end

    // Bus line 0 carries the MSB of each status byte
    assign read_bus_msb_line = q.bus[0]; // RL4
    assign read_bus_rest_lines = q.bus[1:7]; // RL4
    assign read_bus_parity_line = q.par;
    assign read_byte_strobe = q.strobe;
    assign transfer_active = q.active;
    assign hard_error_line = q.hard;

    // Helper: strobes seen in the current sense transfer
    logic [3:0] sent_q;
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            sent_q <= 4'h0;
        else if (go_rise && !q.active)
            sent_q <= 4'h0;
        else if (d.strobe && !q.strobe)
            sent_q <= sent_q + 4'h1;
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_strobe_rise;
        !read_byte_strobe ##1 read_byte_strobe;
    endsequence

    sequence s_strobe_fall;
        read_byte_strobe ##1 !read_byte_strobe;
    endsequence

    sequence s_strobe_pulse;
        read_byte_strobe[*8] ##1 read_byte_strobe[*2] ##1 !read_byte_strobe;
    endsequence

    sequence s_setup_wait;
        !read_byte_strobe[*5] ##1 read_byte_strobe;
    endsequence

    AST_EIGHT_BYTES: assert property ($fell(transfer_active) |-> sent_q == 4'h8) // RL1
        else $error("Sense transfer did not send eight bytes");

    AST_DATA_BEFORE_STROBE: assert property (s_strobe_rise |-> // RL2
        $stable({read_bus_msb_line, read_bus_rest_lines}))
        else $error("Read bus changed as the strobe rose");

    AST_DATA_HELD_STROBE: assert property (s_strobe_fall |-> // RL2
        $stable({read_bus_msb_line, read_bus_rest_lines, read_bus_parity_line}))
        else $error("Read bus changed while the strobe was high");

    AST_ODD_PARITY: assert property (transfer_active |-> // RL5
        ^{read_bus_msb_line, read_bus_rest_lines, read_bus_parity_line})
        else $error("Sense byte parity is not odd");

    AST_FIRST_BYTE: assert property (s_strobe_rise ##0 (sent_q == 4'h1) |-> // RL4
        {read_bus_msb_line, read_bus_rest_lines} == q.snap[0])
        else $error("First sense byte is not general status");

    AST_UNIT_CHECK: assert property (transfer_active && q.idx == 3'h0 |-> // RL11
        read_bus_rest_lines[6] == (read_bus_msb_line | read_bus_rest_lines[1]
        | read_bus_rest_lines[3] | read_bus_rest_lines[4] | read_bus_rest_lines[5]))
        else $error("Unit check does not match its sources");

    AST_DATA_CHECK: assert property ((|rw_errors[5:7]) |-> b0[4] && b0[6]) // RL9
        else $error("Data check missing for a byte 3 error");

    AST_UNIT_EXCEPTION: assert property (corrected_err[1] |-> b0[7]) // RL12
        else $error("Unit exception missing for corrected error");

    AST_HARD_ERROR: assert property (##1 hard_error_line == $past(any_hard)) // RL15
        else $error("Hard error line does not follow errors");

    AST_OVERRUN: assert property (ovr_evt |=> q.overrun && q.illegal ##1 b0[5]) // RL10
        else $error("Command overrun not flagged");

    AST_LAST_CMD: assert property (transfer_active && q.idx == 3'h1 |-> // RL13
        read_bus_msb_line == q.last_cmd[7] && read_bus_rest_lines[7] == q.last_cmd[0])
        else $error("Last command byte not bit-reversed");

    AST_REJ_NOT_READY: assert property (not_ready |-> b5[2:7] == 6'h01 && b4[4]) // RL19
        else $error("Not ready reject code wrong");

    AST_OP_INCOMPLETE: assert property (rej == 6'h0c |-> b4[6]) // RL20
        else $error("Operation incomplete missing for asterisked code");

    AST_UNUSED_ZERO: assert property (!b3[4] && !b4[1] && !b4[3] && !b5[1] && !b6[6]) // RL6
        else $error("Unused status bit is set");

    AST_ACTIVE_HOLD: assert property ($rose(transfer_active) |-> // RL23
        transfer_active[*8] ##1 transfer_active[*8])
        else $error("Transfer-active dropped early");

    AST_STROBE_WIDTH: assert property (s_strobe_rise |-> s_strobe_pulse) // RL2
        else $error("Read strobe pulse has the wrong width");

    AST_SETUP_FIRST: assert property ($rose(transfer_active) |-> s_setup_wait) // RL2
        else $error("First strobe did not follow the setup time");

    AST_HARD_REJECT: assert property (rej != tsr_pkg::REJ_NONE |=> hard_error_line) // RL15
        else $error("Hard error line missing for a command reject");

    AST_DATA_CHECK_B4: assert property ((bot_before_backward | pe_write_track_err) |-> // RL9
        b0[4] && b0[6])
        else $error("Data check missing for a byte 4 error");

    // Idle bus shows zeros so a late host strobe sample reads nothing stale
    AST_BUS_IDLE: assert property (!transfer_active |-> !read_byte_strobe // RL23
        && !read_bus_parity_line && ({read_bus_msb_line, read_bus_rest_lines} == 8'h00))
        else $error("Read bus active outside a sense transfer");

endmodule

// ==== verif/tsr_host.sv ====
// Host-side capture of the eight sense bytes from the read bus.
// Assumes the bench clock and the reporter's registered bus outputs.
`timescale 1ns/1ps
module tsr_host (
    input wire logic core_clk,
    input wire logic clr,
    input wire logic [7:0] bus,
    input wire logic par,
    input wire logic strobe
);
    logic [7:0] bytes [8];
    logic [7:0] prev = 8'h00;
    logic st_q = 1'b0;
    logic [3:0] nb = 4'h0;
    logic ok = 1'b1;
    // Byte taken at the strobe's rise; its width is never policed
    always @(posedge core_clk)
    begin
        prev <= bus;
        st_q <= strobe;
        if (clr)
        begin
            nb <= 4'h0;
            ok <= 1'b1;
        end
        else if (strobe && !st_q)
        begin
            if (nb < 4'h8)
                bytes[nb[2:0]] <= bus;
            nb <= nb + 4'h1;
            if (bus !== prev || ^{bus, par} !== 1'b1)
                ok <= 1'b0;
        end
    end
endmodule

// ==== verif/tape_sense_status_reporter_test.sv ====
// Self-checking bench for the sense status reporter.
// Assumes the host capture model tsr_host and a 50 MHz core clock.
`timescale 1ns/1ps
module tape_sense_status_reporter_test;
    logic core_clk = 1'b0, rst_b = 1'b0, go = 1'b0, ill_evt = 1'b0, clr = 1'b1;
    logic [7:0] code = 8'h00, last_cmd = 8'h00;
    logic nrdy = 1'b0, strm = 1'b1, fault = 1'b0, bot = 1'b0, pe = 1'b0;
    logic bpar = 1'b0, inc = 1'b0, ovr = 1'b0, wrt = 1'b0, bseq = 1'b0;
    logic cache = 1'b0, diag = 1'b0, dtp = 1'b0, ill_e = 1'b0, ovr_e = 1'b0;
    logic [0:7] tape = 8'h00, rwe = 8'h00, dead = 8'h00;
    logic [5:0] ext = 6'h00;
    logic [0:2] corr = 3'h0, gap = 3'h0;
    logic msb, par, strobe, ta, hard, exp_hard;
    logic [1:7] rest;
    logic [7:0] exp_b [8];
    int errors = 0, total_checks = 0, cycles = 0;

    tsr_sense dut (.core_clk(core_clk), .rst_b(rst_b), .cmd_go_pin(go), .cmd_code_pin(code),
        .illegal_cmd_evt(ill_evt), .not_ready(nrdy), .streaming_drive(strm),
        .fault_code_shown(fault), .tape_status(tape), .rw_errors(rwe),
        .bot_before_backward(bot), .pe_write_track_err(pe), .bus_parity_err(bpar),
        .op_incomplete_in(inc), .overrun_err(ovr), .write_type_cmd(wrt),
        .bad_sequence(bseq), .cache_read_empty(cache), .reject_code_ext(ext),
        .diag_mode(diag), .corrected_err(corr), .gap_select(gap), .dead_track_p(dtp),
        .dead_tracks(dead), .read_bus_msb_line(msb), .read_bus_rest_lines(rest),
        .read_bus_parity_line(par), .read_byte_strobe(strobe), .transfer_active(ta),
        .hard_error_line(hard));
    tsr_host host (.core_clk(core_clk), .clr(clr), .bus({msb, rest}), .par(par),
        .strobe(strobe));

    initial
    begin
        forever #10 core_clk = ~core_clk;
    end

    task automatic results();
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Whole run is about 2100 cycles
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            results();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [5:0] rej_code();
        if (nrdy) return 6'h01;
        if (wrt && tape[3]) return 6'h05;
        if (bseq) return 6'h07;
        if (cache) return 6'h10;
        return ext;
    endfunction

    task automatic expect_bytes();
        logic [5:0] rc;
        logic [7:0] b3;
        logic [7:0] b4;
        logic dc;
        rc = rej_code();
        b3 = rwe & 8'hf7;
        b4 = {bot, 1'b0, pe, 1'b0, rc != 6'h00, bpar, inc, ovr};
        if (rc inside {6'h02, 6'h03, 6'h06, 6'h08, 6'h09, 6'h0c, 6'h0f, 6'h10, 6'h11})
            b4[1] = 1'b1;
        dc = (|b3) | bot | pe;
        exp_b[0] = {ill_e, nrdy, strm, fault, dc, ovr_e,
            ill_e | nrdy | fault | dc | ovr_e, |corr};
        exp_b[1] = last_cmd;
        exp_b[2] = tape;
        exp_b[3] = b3;
        exp_b[4] = b4;
        exp_b[5] = {diag, 1'b0, rc};
        exp_b[6] = {corr, gap, 1'b0, dtp};
        exp_b[7] = dead;
        exp_hard = (|b3) | (|b4);
    endtask

    // Optionally raises a second command in mid-transfer
    task automatic sense(input logic ovr_cmd);
        int n;
        expect_bytes();
        @(posedge core_clk);
        go <= 1'b1;
        code <= 8'h04;
        @(posedge core_clk);
        clr <= 1'b0;
        n = 0;
        while (ta !== 1'b1 && n < 20)
        begin
            @(negedge core_clk);
            n++;
        end
        n = 0;
        do
        begin
            @(posedge core_clk);
            go <= ovr_cmd && n >= 20 && n < 30;
            if (ovr_cmd)
                code <= 8'h81;
            @(negedge core_clk);
            n++;
        end
        while (ta === 1'b1 && n < 400);
        check(8'(n), 8'ha0);
        check({4'h0, host.nb}, 8'h08);
        check({7'h0, host.ok}, 8'h01);
        for (int i = 0; i < 8; i++)
            check(host.bytes[i], exp_b[i]);
        check({7'h0, hard}, {7'h0, exp_hard});
        ill_e = ovr_cmd;
        ovr_e = ovr_cmd;
        @(posedge core_clk);
        clr <= 1'b1;
    endtask

    task automatic command(input logic [7:0] c);
        @(posedge core_clk);
        go <= 1'b1;
        code <= c;
        repeat (8) @(posedge core_clk);
        go <= 1'b0;
        repeat (8) @(posedge core_clk);
        last_cmd = c;
    endtask

    task automatic t_status();
        @(posedge core_clk);
        tape <= 8'h5a;
        rwe <= 8'h08;
        dead <= 8'hc3;
        corr <= 3'b010;
        gap <= 3'b100;
        dtp <= 1'b1;
        diag <= 1'b1;
        fault <= 1'b1;
        command(8'h2d);
        sense(1'b0);
        fault <= 1'b0;
        strm <= 1'b0;
    endtask

    task automatic t_errors();
        for (int i = 0; i < 10; i++)
        begin
            @(posedge core_clk);
            rwe <= (i < 8) ? 8'h80 >> i : 8'h00;
            bot <= i == 8;
            pe <= i == 9;
            repeat (2) @(posedge core_clk);
            @(negedge core_clk);
            check({7'h0, hard}, {7'h0, i != 4});
        end
        sense(1'b0);
        pe <= 1'b0;
    endtask

    // Lower-priority causes stay set to prove the priority order
    task automatic t_reject();
        for (int k = 0; k < 7; k++)
        begin
            @(posedge core_clk);
            nrdy <= k == 0;
            wrt <= k <= 1;
            bseq <= k <= 2;
            cache <= k <= 3;
            ext <= (k == 5) ? 6'h04 : (k == 6) ? 6'h00 : 6'h0c;
            bpar <= k == 5;
            inc <= k == 6;
            ovr <= k == 6;
            @(posedge core_clk);
            sense(1'b0);
        end
    endtask

    task automatic t_overrun();
        @(posedge core_clk);
        ill_evt <= 1'b1;
        @(posedge core_clk);
        ill_evt <= 1'b0;
        ill_e = 1'b1;
        sense(1'b1);
        sense(1'b0);
        sense(1'b0);
    endtask

    initial
    begin
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge core_clk);
        t_status();
        t_errors();
        t_reject();
        t_overrun();
        results();
    end
endmodule
